//--- design/tdp_digipot_slave.v
// Two-wire slave and register core of a single digital potentiometer
// What this block does
// - Outside reset, volatile wiper register selects exactly one of 256 taps.
// - Sixteen nonvolatile data registers, writable and readable by master.
// - After power-up the default saved setting is loaded into wiper.
// - Supports read, write and register-to-wiper transfer commands.
// - Incoming bits on SDA are sampled on each SCL rising edge.
// - Outgoing SDA changes only after an SCL falling edge.
// - SDA is open drain: pulled low or released, never driven high.
// - Strap pins form the three low bits of the slave address.
// - Commands start only when received address matches strap pins.
// - Nonvolatile data writes are refused while write-lock input is low.
// - Upper address nibble must match the fixed device type nibble.
// - Acknowledge on ninth clock after address, command and data byte.
// - Address acknowledge is withheld while a nonvolatile write runs.
`include "tdp_defs.vh"

module tdp_digipot_slave #(
    parameter CNT_W = `TDP_NV_CNT_W,
    parameter [CNT_W-1:0] NV_WRITE_CYCLES = `TDP_NV_WRITE_CYC,
    parameter [3:0] DEVICE_TYPE = `TDP_TYPE_NIBBLE
) (
    input wire mclk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [2:0] addr_strap_pins,
    input wire wr_lock_b,
    output wire [7:0] wiper_position_reg,
    output wire [`TDP_NUM_TAPS-1:0] tap_sel,
    output wire nv_busy
);

// ==========================================================
// States
localparam [9:0] S_IDLE = 10'h0_001;
localparam [9:0] S_ADDR = 10'h0_002;
localparam [9:0] S_ACKA = 10'h0_004;
localparam [9:0] S_INSTR = 10'h0_008;
localparam [9:0] S_ACKI = 10'h0_010;
localparam [9:0] S_WDATA = 10'h0_020;
localparam [9:0] S_ACKD = 10'h0_040;
localparam [9:0] S_RDATA = 10'h0_080;
localparam [9:0] S_RACK = 10'h0_100;
localparam [9:0] S_WAIT = 10'h0_200;
localparam [CNT_W-1:0] NV_LAST = NV_WRITE_CYCLES - 1'b1;

reg [9:0] state_r;
reg [3:0] cnt_r;
reg [7:0] sh_r;
reg [7:0] tx_r;
reg [2:0] op_r;
reg [3:0] idx_r;
reg [7:0] wiper_r;
reg pend_r;
reg [3:0] pend_idx_r;
reg [7:0] pend_val_r;
reg busy_r;
reg [CNT_W-1:0] busy_cnt_r;
reg sda_oe_r;
reg sda_out_r;
reg ready_r;
reg [2:0] strap_s1_r;
reg [2:0] strap_s2_r;
reg lock_s1_r;
reg lock_s2_r;
reg [`TDP_NUM_TAPS-1:0] tap_r;
reg [7:0] dr_mem [0:`TDP_NUM_DR-1];

wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire sda_lvl;

// ==========================================================
// Line sensing; SCL is only ever an input here
tdp_bus_sense u_sense (
    .mclk(mclk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sda_lvl(sda_lvl)
);

// Straps and lock are pins too, so they get two flops as well
always @(posedge mclk) begin
    if (!rst_b) begin
        strap_s1_r <= 3'h0_000;
        strap_s2_r <= 3'h0_000;
        lock_s1_r <= 1'b0;
        lock_s2_r <= 1'b0;
    end else begin
        strap_s1_r <= addr_strap_pins;
        strap_s2_r <= strap_s1_r;
        lock_s1_r <= wr_lock_b;
        lock_s2_r <= lock_s1_r;
    end
end

// ==========================================================
// Byte decode
wire rx_st = state_r[1] | state_r[3] | state_r[5];
wire byte_done = (cnt_r == `TDP_BYTE_BITS);
wire addr_ok = (sh_r[`TDP_TYPE_HI:`TDP_TYPE_LO] == DEVICE_TYPE) &&
    (sh_r[`TDP_STRAP_HI:`TDP_STRAP_LO] == strap_s2_r) &&
    !busy_r;
wire [2:0] sh_op = sh_r[`TDP_OP_HI:`TDP_OP_LO];
wire sh_bank0 = (sh_r[`TDP_BANK_HI:`TDP_BANK_LO] == 2'h0_000);
wire op_xfer = (sh_op == `TDP_OP_DATA_TO_WIPER) ||
    (sh_op == `TDP_OP_WIPER_TO_DATA);
wire op_plain = (sh_op == `TDP_OP_RD_WIPER) ||
    (sh_op == `TDP_OP_WR_WIPER) || (sh_op == `TDP_OP_RD_DATA) ||
    (sh_op == `TDP_OP_WR_DATA);
// Transfers only reach bank 0; a non-zero pot select is not us
wire instr_ok = !sh_r[`TDP_POT_BIT] && (op_plain || (op_xfer && sh_bank0));
wire op_rd = (op_r == `TDP_OP_RD_WIPER) || (op_r == `TDP_OP_RD_DATA);
wire [7:0] rd_val = (op_r == `TDP_OP_RD_WIPER) ? wiper_r : dr_mem[idx_r];
// Nonvolatile write begins at stop, only when the lock is released
wire nv_commit = ready_r && stop_det && pend_r && lock_s2_r;

// ==========================================================
// Nonvolatile data registers; contents survive reset by design
integer k;
initial begin
    for (k = 0; k < `TDP_NUM_DR; k = k + 1) begin
        dr_mem[k] = `TDP_NV_INIT;
    end
end

always @(posedge mclk) begin
    if (nv_commit) begin
        dr_mem[pend_idx_r] <= pend_val_r;
    end
end

// ==========================================================
// Protocol engine
always @(posedge mclk) begin
    if (!rst_b) begin
        state_r <= S_IDLE;
        cnt_r <= 4'h0_000;
        sh_r <= 8'h0_000;
        tx_r <= 8'h0_000;
        op_r <= 3'h0_000;
        idx_r <= 4'h0_000;
        wiper_r <= `TDP_WIPER_RST;
        pend_r <= 1'b0;
        pend_idx_r <= 4'h0_000;
        pend_val_r <= 8'h0_000;
        busy_r <= 1'b0;
        busy_cnt_r <= {CNT_W{1'b0}};
        sda_oe_r <= 1'b0;
        sda_out_r <= 1'b0;
        ready_r <= 1'b0;
    end else begin
        sda_out_r <= 1'b0; // Never drive high
        if (!ready_r) begin
            wiper_r <= dr_mem[0]; // Recall before serving the bus
            ready_r <= 1'b1;
        end
        if (nv_commit) begin
            busy_r <= 1'b1;
            busy_cnt_r <= {CNT_W{1'b0}};
        end else if (busy_r) begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
            if (busy_cnt_r == NV_LAST) begin
                busy_r <= 1'b0;
            end
        end
        if (!ready_r) begin
            state_r <= S_IDLE;
        end else if (start_det) begin
            // Repeated start abandons any pending store
            state_r <= S_ADDR;
            cnt_r <= 4'h0_000;
            sda_oe_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= S_IDLE;
            cnt_r <= 4'h0_000;
            sda_oe_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            if (scl_rise && (rx_st || state_r == S_RDATA)) begin
                cnt_r <= cnt_r + 4'h0_001;
            end
            if (scl_rise && rx_st) begin
                sh_r <= {sh_r[6:0], sda_lvl}; // MSB first
            end
            if (scl_fall) begin // All SDA changes follow a fall
                case (state_r)
                    S_ADDR: begin
                        if (byte_done) begin
                            cnt_r <= 4'h0_000;
                            if (addr_ok) begin
                                sda_oe_r <= 1'b1;
                                state_r <= S_ACKA;
                            end else begin
                                state_r <= S_WAIT;
                            end
                        end
                    end
                    S_ACKA: begin
                        sda_oe_r <= 1'b0;
                        state_r <= S_INSTR;
                    end
                    S_INSTR: begin
                        if (byte_done) begin
                            cnt_r <= 4'h0_000;
                            if (instr_ok) begin
                                sda_oe_r <= 1'b1;
                                op_r <= sh_op;
                                idx_r <= sh_r[`TDP_IDX_HI:`TDP_IDX_LO];
                                state_r <= S_ACKI;
                            end else begin
                                state_r <= S_WAIT;
                            end
                        end
                    end
                    S_ACKI: begin
                        if (op_rd) begin
                            tx_r <= rd_val;
                            sda_oe_r <= ~rd_val[7];
                            state_r <= S_RDATA;
                        end else if (op_r == `TDP_OP_DATA_TO_WIPER) begin
                            wiper_r <= dr_mem[idx_r];
                            sda_oe_r <= 1'b0;
                            state_r <= S_WAIT;
                        end else if (op_r == `TDP_OP_WIPER_TO_DATA) begin
                            pend_r <= 1'b1;
                            pend_idx_r <= idx_r;
                            pend_val_r <= wiper_r;
                            sda_oe_r <= 1'b0;
                            state_r <= S_WAIT;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r <= S_WDATA;
                        end
                    end
                    S_WDATA: begin
                        if (byte_done) begin
                            cnt_r <= 4'h0_000;
                            sda_oe_r <= 1'b1;
                            state_r <= S_ACKD;
                            if (op_r == `TDP_OP_WR_WIPER) begin
                                wiper_r <= sh_r;
                            end else begin
                                pend_r <= 1'b1;
                                pend_idx_r <= idx_r;
                                pend_val_r <= sh_r;
                            end
                        end
                    end
                    S_ACKD: begin
                        sda_oe_r <= 1'b0;
                        state_r <= S_WAIT;
                    end
                    S_RDATA: begin
                        if (byte_done) begin
                            cnt_r <= 4'h0_000;
                            sda_oe_r <= 1'b0; // Master owns the ninth bit
                            state_r <= S_RACK;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe_r <= ~tx_r[6];
                        end
                    end
                    S_RACK: begin
                        state_r <= S_WAIT;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
end

// ==========================================================
// One-hot tap switch select, one bit per tap
genvar gi;
generate
    for (gi = 0; gi < `TDP_NUM_TAPS; gi = gi + 1) begin : g_tap
        localparam [7:0] TAP_IDX = gi;
        always @(posedge mclk) begin
            if (!rst_b) begin
                tap_r[gi] <= 1'b0;
            end else begin
                tap_r[gi] <= (wiper_r == TAP_IDX);
            end
        end
    end
endgenerate

assign sda_out = sda_out_r;
assign sda_oe = sda_oe_r;
assign wiper_position_reg = wiper_r;
assign tap_sel = tap_r;
assign nv_busy = busy_r;

endmodule // tdp_digipot_slave

//--- pkg/tdp_defs.vh
// Constants for the two-wire digipot slave: codes, sizes and timing
`ifndef TDP_DEFS_VH
`define TDP_DEFS_VH

// ==========================================================
// Address byte
// Device type nibble value is arbitrary
`define TDP_TYPE_NIBBLE 4'h0_00A
`define TDP_TYPE_HI 7
`define TDP_TYPE_LO 4
`define TDP_STRAP_HI 2
`define TDP_STRAP_LO 0

// ==========================================================
// Instruction byte: opcode, bank, register, pot select
`define TDP_OP_HI 7
`define TDP_OP_LO 5
`define TDP_IDX_HI 4
`define TDP_IDX_LO 1
`define TDP_BANK_HI 4
`define TDP_BANK_LO 3
`define TDP_POT_BIT 0
`define TDP_OP_RD_WIPER 3'h0_004
`define TDP_OP_WR_WIPER 3'h0_005
`define TDP_OP_RD_DATA 3'h0_006
`define TDP_OP_WR_DATA 3'h0_007
`define TDP_OP_DATA_TO_WIPER 3'h0_002
`define TDP_OP_WIPER_TO_DATA 3'h0_003

// ==========================================================
// Sizes and reset values
`define TDP_NUM_DR 16
`define TDP_NUM_TAPS 256
`define TDP_BYTE_BITS 4'h0_008
`define TDP_NV_INIT 8'h0_080
`define TDP_WIPER_RST 8'h0_000

// ==========================================================
// Timing: nonvolatile write cycle
`define TDP_NV_WRITE_MS 5
`define TDP_CLK_KHZ 100000
`define TDP_NV_WRITE_CYC (`TDP_NV_WRITE_MS * `TDP_CLK_KHZ)
`define TDP_NV_CNT_W 20

`endif

//--- design/tdp_bus_sense.v
// Two-flop synchronisers and edge, start and stop detection for SCL/SDA
module tdp_bus_sense (
    input wire mclk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_in,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det,
    output wire sda_lvl
);

// ==========================================================
// Synchronisers; idle bus is high, so reset to one
reg scl_s1_r;
reg scl_s2_r;
reg scl_d_r;
reg sda_s1_r;
reg sda_s2_r;
reg sda_d_r;

always @(posedge mclk) begin
    if (!rst_b) begin
        scl_s1_r <= 1'b1;
        scl_s2_r <= 1'b1;
        scl_d_r <= 1'b1;
        sda_s1_r <= 1'b1;
        sda_s2_r <= 1'b1;
        sda_d_r <= 1'b1;
    end else begin
        scl_s1_r <= scl_in;
        scl_s2_r <= scl_s1_r;
        scl_d_r <= scl_s2_r;
        sda_s1_r <= sda_in;
        sda_s2_r <= sda_s1_r;
        sda_d_r <= sda_s2_r;
    end
end

// ==========================================================
// Events, one-cycle pulses on mclk; sda_lvl is the synchronised SDA level
assign scl_rise = scl_s2_r & ~scl_d_r;
assign scl_fall = ~scl_s2_r & scl_d_r;
// SDA moving while SCL stays high marks start or stop
assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
assign sda_lvl = sda_s2_r;

endmodule // tdp_bus_sense

//--- sim/tdp_digipot_slave_sva.sv
// Port-level checker for the two-wire digipot slave
`include "tdp_defs.vh"
module tdp_digipot_slave_sva #(
    parameter CNT_W = 20,
    parameter [CNT_W-1:0] NV_WRITE_CYCLES = 200,
    parameter [3:0] DEVICE_TYPE = 4'hA
) (
    input logic mclk,
    input logic rst_b,
    input logic scl_in,
    input logic sda_in,
    input logic sda_out,
    input logic sda_oe,
    input logic [2:0] addr_strap_pins,
    input logic wr_lock_b,
    input logic [7:0] wiper_position_reg,
    input logic [255:0] tap_sel,
    input logic nv_busy
);
    // ==========================================
    // Helper: length of the current busy spell
    logic [CNT_W:0] busy_cnt_r;
    always @(posedge mclk) begin
        if (!rst_b || !nv_busy) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // Assertions
    AST_SDA_NEVER_HIGH: assert property (
        sda_out == 1'b0) else $error("sda driven high");
    AST_TAP_ONE_HOT: assert property (
        $past(rst_b) && $past(rst_b, 2) |->
        tap_sel == (256'h1 << $past(wiper_position_reg)))
        else $error("tap select not decode of wiper");
    AST_OE_MOVES_SCL_LOW: assert property (
        $changed(sda_oe) |-> !scl_in) else $error("sda moved in scl high");
    // Holds only while the default setting is never rewritten
    AST_RECALL: assert property (
        $rose(rst_b) |=> wiper_position_reg == `TDP_NV_INIT)
        else $error("wiper not recalled");
    AST_WIPER_SCL_LOW: assert property (
        $past(rst_b, 2) && $changed(wiper_position_reg) |-> !scl_in)
        else $error("wiper moved in scl high");
    AST_BUSY_LENGTH: assert property (
        $fell(nv_busy) |-> busy_cnt_r == NV_WRITE_CYCLES)
        else $error("busy spell wrong length");
    AST_BUSY_BOUND: assert property (
        busy_cnt_r <= NV_WRITE_CYCLES) else $error("busy too long");
    AST_BUSY_SILENT: assert property (
        nv_busy |-> !sda_oe) else $error("ack while busy");
    AST_LOCK_NO_WRITE: assert property (
        $rose(nv_busy) |-> wr_lock_b && $past(wr_lock_b, 8))
        else $error("write under lock");
endmodule // tdp_digipot_slave_sva

bind tdp_digipot_slave tdp_digipot_slave_sva #(.CNT_W(CNT_W),
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES), .DEVICE_TYPE(DEVICE_TYPE)) u_sva (
    .mclk(mclk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pins(addr_strap_pins),
    .wr_lock_b(wr_lock_b), .wiper_position_reg(wiper_position_reg),
    .tap_sel(tap_sel), .nv_busy(nv_busy));

//--- sim/tdp_master_model.sv
// Two-wire bus master model: drives SCL and pulls SDA
module tdp_master_model (
    input logic mclk,
    input logic sda,
    output logic scl,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Bus phases; SCL rests high between frames
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // SDA only moves in the low phase, so no false start or stop
    task automatic put_bit(input logic b);
        wt(4);
        sda_oe = ~b;
        wt(4);
        scl = 1'b1;
        wt(8);
        scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        wt(4);
        sda_oe = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(7);
        b = sda;
        wt(1);
        scl = 1'b0;
    endtask
    task automatic start();
        wt(4);
        sda_oe = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda_oe = 1'b1;
        wt(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(4);
        sda_oe = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda_oe = 1'b0;
        wt(8);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask
    task automatic rbyte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
    endtask
endmodule // tdp_master_model

//--- sim/tdp_digipot_slave_test.sv
// Self-checking bench for the two-wire digipot slave
`include "tdp_defs.vh"
module tdp_digipot_slave_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] BASE = {`TDP_TYPE_NIBBLE, 4'h0};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_lock_b = 1'b1;
    logic [2:0] strap = 3'h5;
    logic scl, m_oe, d_oe, d_out, busy;
    logic [7:0] wiper;
    logic [255:0] tap;
    // Pull-up: the wire is low when either party pulls it
    wire sda = ~m_oe & (d_oe ? d_out : 1'b1);
    int errors = 0;
    int comparisons = 0;
    logic [10:0] rows [4] = '{{3'h5, 8'h00}, {3'h2, 8'hFF},
        {3'h0, 8'h01}, {3'h7, 8'hA5}};
    always #5 mclk = ~mclk;
    tdp_master_model u_mst (.mclk(mclk), .sda(sda), .scl(scl),
        .sda_oe(m_oe));
    tdp_digipot_slave #(.CNT_W(20), .NV_WRITE_CYCLES(200)) dut (
        .mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(d_out), .sda_oe(d_oe), .addr_strap_pins(strap),
        .wr_lock_b(wr_lock_b), .wiper_position_reg(wiper),
        .tap_sel(tap), .nv_busy(busy));
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] adr();
        return BASE | {5'h0, strap};
    endfunction
    function automatic logic [7:0] ins(input logic [2:0] op,
        input logic [3:0] idx);
        return {op, idx, 1'b0};
    endfunction
    // Mode 0 no data byte, 1 write byte, 2 read byte
    task automatic cmd(input logic [7:0] ad, input logic [7:0] in,
        input logic [7:0] dt, input int mode, output logic [2:0] ack,
        output logic [7:0] rd);
        ack = 3'h0;
        rd = 8'h00;
        u_mst.start();
        u_mst.wbyte(ad, ack[2]);
        if (ack[2]) u_mst.wbyte(in, ack[1]);
        if (ack[1] && mode == 1) u_mst.wbyte(dt, ack[0]);
        if (ack[1] && mode == 2) u_mst.rbyte(rd);
        u_mst.stop();
    endtask
    // Address polling until the write cycle is over
    task automatic poll(output int n);
        logic a;
        n = 0;
        a = 1'b0;
        while (!a && n < 50) begin
            u_mst.start();
            u_mst.wbyte(adr(), a);
            u_mst.stop();
            n++;
        end
    endtask
    task automatic rdd(input logic [3:0] idx, input logic [7:0] exp);
        logic [2:0] a;
        logic [7:0] rd;
        cmd(adr(), ins(`TDP_OP_RD_DATA, idx), 8'h00, 2, a, rd);
        chk(rd, exp);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic [2:0] ack;
        logic [7:0] rd;
        int n;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        repeat (8) @(negedge mclk);
        chk(wiper, `TDP_NV_INIT);
        foreach (rows[i]) begin
            strap = rows[i][10:8];
            cmd(adr(), ins(`TDP_OP_WR_WIPER, 4'h0), rows[i][7:0], 1, ack, rd);
            chk(ack, 3'h7);
            chk(wiper, rows[i][7:0]);
            chk(tap, 256'h1 << rows[i][7:0]);
            cmd(adr(), ins(`TDP_OP_RD_WIPER, 4'h0), 8'h00, 2, ack, rd);
            chk(rd, rows[i][7:0]);
        end
        cmd(adr() ^ 8'h01, ins(`TDP_OP_RD_WIPER, 4'h0), 8'h00, 2, ack, rd);
        chk(ack, 3'h0);
        cmd(adr() ^ 8'h40, ins(`TDP_OP_RD_WIPER, 4'h0), 8'h00, 2, ack, rd);
        chk(ack, 3'h0);
        cmd(adr(), ins(`TDP_OP_WR_WIPER, 4'h0) | 8'h01, 8'h12, 1, ack, rd);
        chk(ack, 3'h4);
        cmd(adr(), ins(3'h0, 4'h0), 8'h12, 1, ack, rd);
        chk(ack, 3'h4);
        cmd(adr(), ins(`TDP_OP_DATA_TO_WIPER, 4'h5), 8'h00, 0, ack, rd);
        chk(ack, 3'h4);
        chk(wiper, 8'hA5);
        cmd(adr(), ins(`TDP_OP_WR_DATA, 4'h5), 8'h3C, 1, ack, rd);
        chk(ack, 3'h7);
        chk(busy, 1'b1);
        poll(n);
        chk(n > 1, 1'b1);
        rdd(4'h5, 8'h3C);
        cmd(adr(), ins(`TDP_OP_WR_DATA, 4'h2), 8'h6E, 1, ack, rd);
        poll(n);
        cmd(adr(), ins(`TDP_OP_DATA_TO_WIPER, 4'h2), 8'h00, 0, ack, rd);
        chk(ack, 3'h6);
        chk(wiper, 8'h6E);
        cmd(adr(), ins(`TDP_OP_WIPER_TO_DATA, 4'h1), 8'h00, 0, ack, rd);
        poll(n);
        rdd(4'h1, 8'h6E);
        wr_lock_b = 1'b0;
        cmd(adr(), ins(`TDP_OP_WR_DATA, 4'h3), 8'h55, 1, ack, rd);
        chk(ack, 3'h7);
        chk(busy, 1'b0);
        rdd(4'h3, `TDP_NV_INIT);
        wr_lock_b = 1'b1;
        // Repeated start after a data byte drops the pending store
        u_mst.start();
        u_mst.wbyte(adr(), ack[2]);
        u_mst.wbyte(ins(`TDP_OP_WR_DATA, 4'h4), ack[1]);
        u_mst.wbyte(8'h99, ack[0]);
        u_mst.start();
        u_mst.wbyte(adr(), ack[2]);
        u_mst.stop();
        chk(ack, 3'h7);
        chk(busy, 1'b0);
        rdd(4'h4, `TDP_NV_INIT);
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        repeat (8) @(negedge mclk);
        chk(wiper, `TDP_NV_INIT);
        rdd(4'h5, 8'h3C);
        conclude();
    end
    // A hang is cut short well past the expected run of some 12k cycles
    initial begin
        #1_000_000;
        errors++;
        conclude();
    end
endmodule // tdp_digipot_slave_test
